/* rtl/lfx_pkg.sv */
// Purpose: Shared constants and types for the LED dot effect memory link
// Assumes: One core clock at 250 MHz on both ends of the byte link
// Notes: Host register offsets are local to the host end
`default_nettype none
package lfx_pkg;
  localparam int unsigned LFX_ROWS = 9;
  localparam int unsigned LFX_COLS = 8;
  localparam int unsigned LFX_DOTS = LFX_ROWS * LFX_COLS;
  localparam int unsigned LFX_PAGES = 16;
  localparam int unsigned LFX_DISP_WORDS = LFX_PAGES * LFX_DOTS;
  localparam int unsigned LFX_FADE_WORDS = LFX_PAGES * LFX_ROWS * 4;

  // Command bytes
  localparam logic [7:0] CMD_PAGE = 8'hfd;
  localparam logic [7:0] CMD_DISP_WR = 8'h80;
  localparam logic [7:0] CMD_DISP_RD = 8'h81;
  localparam logic [7:0] CMD_FADE_WR = 8'h82;
  localparam logic [7:0] CMD_FADE_RD = 8'h83;
  localparam logic [7:0] CMD_MASK_WR = 8'h84;
  localparam logic [7:0] CMD_MASK_RD = 8'h85;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;

  // Address limits and layout
  localparam logic [7:0] DISP_LAST = 8'h87;
  localparam logic [7:0] BIN_LAST = 8'h08;
  localparam logic [7:0] FADE_LAST = 8'h83;
  localparam logic [7:0] MASK_LAST = 8'h08;
  localparam logic [2:0] DISP_ROW_LAST_COL = 3'h7;
  localparam logic [1:0] FADE_ROW_LAST_BYTE = 2'h3;
  localparam logic [7:0] MASK_ADDR_FIELD = 8'h1f;
  localparam logic [7:0] PAGE_FIELD = 8'h0f;

  // Fade nibble fields: low nibble first dot, high nibble second dot
  localparam int unsigned FX_MODE_BIT = 3;
  localparam int unsigned FX_NIB_W = 4;
  localparam logic FX_MODE_FADE = 1'b0;

  // Reset values
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [7:0] DISP_RST = 8'h00;
  localparam logic [7:0] FADE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;

  // Frame timing: (256+16) system clocks per row, 9 rows, system clock 2.4 MHz
  localparam longint unsigned SYS_HZ = 64'd2400000;
  localparam longint unsigned CORE_HZ = 64'd250000000;
  localparam longint unsigned ROW_SYS_CLKS = 64'd256 + 64'd16;
  localparam longint unsigned FRAME_SYS_CLKS = ROW_SYS_CLKS * LFX_ROWS;
  localparam int unsigned FRAME_CYC_DEF = int'((FRAME_SYS_CLKS * CORE_HZ) / SYS_HZ);
  localparam int unsigned FX_UNIT_FRAMES = 256;
  // Two halves of every period fit whole in 240 units (twice lcm of 1,2,4,6,8,10,12)
  localparam logic [15:0] FX_FRAME_WRAP = 16'(240 * FX_UNIT_FRAMES - 1);

  // Host register offsets
  localparam logic [3:0] HR_CMD = 4'h0;
  localparam logic [3:0] HR_TX = 4'h1;
  localparam logic [3:0] HR_RX = 4'h2;
  localparam logic [3:0] HR_FRAME = 4'h3;
  localparam logic [3:0] HR_STAT = 4'h4;

  typedef enum logic [1:0] {KIND_DISP, KIND_FADE, KIND_MASK} lfx_kind_e;
  typedef enum {DS_CMD, DS_PAGE, DS_ADDR, DS_WDATA, DS_RDUMMY, DS_RDATA, DS_IGNORE} lfx_dev_state_e;
  typedef enum {HS_IDLE, HS_CLOSE, HS_CMD, HS_ARG} lfx_host_state_e;

  // Period code to multiples of 256 frames
  function automatic logic [7:0] lfx_period_units(input logic [2:0] code);
    case (code)
      3'd1: lfx_period_units = 8'd1;
      3'd2: lfx_period_units = 8'd2;
      3'd3: lfx_period_units = 8'd4;
      3'd4: lfx_period_units = 8'd6;
      3'd5: lfx_period_units = 8'd8;
      3'd6: lfx_period_units = 8'd10;
      3'd7: lfx_period_units = 8'd12;
      default: lfx_period_units = 8'd0;
    endcase
  endfunction
endpackage
`default_nettype wire

/* rtl/lfx_link_if.sv */
// Purpose: Byte-level command link between host and LED effect device
// Assumes: Both ends on core_clk, strobes one cycle wide
// Notes: rd_vld answers rd_stb exactly one cycle later
`default_nettype none
interface lfx_link_if (
  input wire logic core_clk,
  input wire logic rstn
);
  logic frm;
  logic wr_stb;
  logic [7:0] wr_data;
  logic rd_stb;
  logic rd_vld;
  logic [7:0] rd_data;

  modport dev (input frm, input wr_stb, input wr_data, input rd_stb, output rd_vld, output rd_data);
  modport host (output frm, output wr_stb, output wr_data, output rd_stb, input rd_vld, input rd_data);
endinterface
`default_nettype wire

/* rtl/lfx_dev.sv */
// Purpose: Device end; command interpreter for display, fade and mask memories
// Assumes: Host keeps frm high for a whole command, one byte per wr_stb
// Notes: dot_level is the effective 8-bit drive of each dot, row major
// Notes on behaviour
// - 36 fade bytes per page, fixed dot map
// - 82h, address, then two-dot parameter bytes
// - Mode bit zero fades, one blinks
// - Period code: off, 256 to 3072 frames
// - Binary mode ignores fade and blink
// - Frames counted from oscillator-derived frame tick
// - Fade row n at (n-1)*10h, low nibble first
// - Fade address auto-increments, wraps after 83h
// - Nine mask bytes, one enables the dot
// - Mask address is row-1, bit k column k+1
// - Mask writes auto-increment, wrap after 08h
// - Binary mode ignores the mask
// - FDh then page in low nibble
// - 80h writes display, 81h reads display
// - Reads return dummy 00h before data
// - Binary display bit per dot, gray byte
// - Gray display wraps after 87h
// - 84h/85h mask access, 5-bit address
`default_nettype none
module lfx_dev
  import lfx_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = FRAME_CYC_DEF
) (
  input wire logic core_clk,
  input wire logic rstn,
  lfx_link_if.dev link,
  input wire logic binary_mode,
  output logic [3:0] page,
  output logic [15:0] frame_count,
  output logic [LFX_DOTS-1:0][7:0] dot_level
);

  lfx_dev_state_e state_q;
  lfx_kind_e kind_q;
  logic [7:0] addr_q;
  logic [3:0] page_q;
  logic rd_vld_q;
  logic [7:0] rd_data_q;
  logic [31:0] div_q;
  logic [15:0] frame_q;
  logic [7:0] disp_mem [LFX_DISP_WORDS];
  logic [7:0] fade_mem [LFX_FADE_WORDS];
  logic [7:0] mask_mem [LFX_ROWS];
  logic [7:0] fx_lvl [8];
  logic fx_on [8];
  logic [7:0] unit_cnt;
  logic [7:0] next_addr;

  ////////////////////////////////////////////////////////////////////////////
  function automatic int unsigned disp_idx(input logic [3:0] pg, input logic [3:0] row, input logic [2:0] col);
    disp_idx = int'(pg) * LFX_DOTS + int'(row) * LFX_COLS + int'(col);
  endfunction

  function automatic int unsigned fade_idx(input logic [3:0] pg, input logic [3:0] row, input logic [1:0] pair);
    fade_idx = int'(pg) * LFX_ROWS * 4 + int'(row) * 4 + int'(pair);
  endfunction

  // Out-of-map addresses are neither stored nor read back
  function automatic logic addr_ok(input lfx_kind_e kind, input logic bin, input logic [7:0] a);
    case (kind)
      KIND_DISP: addr_ok = bin ? (a <= BIN_LAST) : (a <= DISP_LAST && !a[3]);
      KIND_FADE: addr_ok = a <= FADE_LAST && a[3:2] == 2'b00;
      KIND_MASK: addr_ok = a <= MASK_LAST;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // Row-wise stepping skips the unused gap inside each 10h block
  function automatic logic [7:0] step_addr(input lfx_kind_e kind, input logic bin, input logic [7:0] a);
    case (kind)
      KIND_DISP: begin
        if (bin) begin
          step_addr = (a >= BIN_LAST) ? 8'h00 : 8'(a + 8'h01);
        end else if (a >= DISP_LAST) begin
          step_addr = 8'h00;
        end else begin
          step_addr = (a[2:0] == DISP_ROW_LAST_COL) ? {4'(a[7:4] + 4'h1), 4'h0} : 8'(a + 8'h01);
        end
      end
      KIND_FADE: begin
        if (a >= FADE_LAST) begin
          step_addr = 8'h00;
        end else begin
          step_addr = (a[1:0] == FADE_ROW_LAST_BYTE) ? {4'(a[7:4] + 4'h1), 4'h0} : 8'(a + 8'h01);
        end
      end
      default: step_addr = (a >= MASK_LAST) ? 8'h00 : 8'(a + 8'h01);
    endcase
  endfunction

  assign next_addr = step_addr(kind_q, binary_mode, addr_q);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencing; a dropped frame always returns to command decode
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= DS_CMD;
      kind_q <= KIND_DISP;
      addr_q <= 8'h00;
      page_q <= PAGE_RST;
    end else if (!link.frm) begin
      state_q <= DS_CMD;
    end else begin
      case (state_q)
        DS_CMD: begin
          if (link.wr_stb) begin
            case (link.wr_data)
              CMD_PAGE: state_q <= DS_PAGE;
              CMD_DISP_WR, CMD_DISP_RD: begin
                kind_q <= KIND_DISP;
                state_q <= DS_ADDR;
              end
              CMD_FADE_WR, CMD_FADE_RD: begin
                kind_q <= KIND_FADE;
                state_q <= DS_ADDR;
              end
              CMD_MASK_WR, CMD_MASK_RD: begin
                kind_q <= KIND_MASK;
                state_q <= DS_ADDR;
              end
              default: state_q <= DS_IGNORE;
            endcase
            addr_q <= {7'h00, link.wr_data[0]};
          end
        end
        DS_PAGE: begin
          if (link.wr_stb) begin
            page_q <= 4'(link.wr_data & PAGE_FIELD);
            state_q <= DS_IGNORE;
          end
        end
        DS_ADDR: begin
          if (link.wr_stb) begin
            addr_q <= (kind_q == KIND_MASK) ? (link.wr_data & MASK_ADDR_FIELD) : link.wr_data;
            state_q <= addr_q[0] ? DS_RDUMMY : DS_WDATA;
          end
        end
        DS_WDATA: if (link.wr_stb) addr_q <= next_addr;
        DS_RDUMMY: if (link.rd_stb) state_q <= DS_RDATA;
        DS_RDATA: if (link.rd_stb) addr_q <= next_addr;
        DS_IGNORE: state_q <= DS_IGNORE;
        default: state_q <= DS_CMD;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < LFX_DISP_WORDS; i++) disp_mem[i] <= DISP_RST;
      for (int i = 0; i < LFX_FADE_WORDS; i++) fade_mem[i] <= FADE_RST;
      for (int i = 0; i < LFX_ROWS; i++) mask_mem[i] <= MASK_RST;
    end else if (link.frm && link.wr_stb && state_q == DS_WDATA && addr_ok(kind_q, binary_mode, addr_q)) begin
      case (kind_q)
        KIND_DISP: begin
          if (binary_mode) begin
            disp_mem[disp_idx(page_q, addr_q[3:0], 3'h0)] <= link.wr_data;
          end else begin
            disp_mem[disp_idx(page_q, addr_q[7:4], addr_q[2:0])] <= link.wr_data;
          end
        end
        KIND_FADE: fade_mem[fade_idx(page_q, addr_q[7:4], addr_q[1:0])] <= link.wr_data;
        KIND_MASK: mask_mem[addr_q[3:0]] <= link.wr_data;
        default: mask_mem[0] <= mask_mem[0];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answers; every read strobe is answered next cycle, never stalled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_vld_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else begin
      rd_vld_q <= link.rd_stb;
      rd_data_q <= DUMMY_BYTE;
      if (link.rd_stb && link.frm && state_q == DS_RDATA && addr_ok(kind_q, binary_mode, addr_q)) begin
        case (kind_q)
          KIND_DISP: rd_data_q <= binary_mode ? disp_mem[disp_idx(page_q, addr_q[3:0], 3'h0)] :
                                  disp_mem[disp_idx(page_q, addr_q[7:4], addr_q[2:0])];
          KIND_FADE: rd_data_q <= fade_mem[fade_idx(page_q, addr_q[7:4], addr_q[1:0])];
          default: rd_data_q <= mask_mem[addr_q[3:0]];
        endcase
      end
    end
  end

  assign link.rd_vld = rd_vld_q;
  assign link.rd_data = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Frame tick and the shared frame counter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 32'h0;
      frame_q <= 16'h0;
    end else if (div_q >= 32'(FRAME_CYCLES - 1)) begin
      div_q <= 32'h0;
      frame_q <= (frame_q >= FX_FRAME_WRAP) ? 16'h0 : 16'(frame_q + 16'h1);
    end else begin
      div_q <= 32'(div_q + 32'h1);
    end
  end

  assign unit_cnt = frame_q[15:8];

  // One ramp and one blink phase per period code, shared by all dots
  assign fx_lvl[0] = 8'hff;
  assign fx_on[0] = 1'b1;
  for (genvar c = 1; c < 8; c++) begin : g_fx
    localparam logic [7:0] M = lfx_period_units(3'(c));
    logic [7:0] pos;
    logic up;
    logic [15:0] sub;
    logic [15:0] q;
    assign pos = 8'(unit_cnt % 8'(8'd2 * M));
    assign up = pos < M;
    assign sub = {(up ? pos : 8'(pos - M)), frame_q[7:0]};
    assign q = 16'(sub / {8'h00, M});
    assign fx_lvl[c] = up ? q[7:0] : ~q[7:0];
    assign fx_on[c] = up;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-dot drive level
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dot_level <= '0;
    end else begin
      for (int r = 0; r < LFX_ROWS; r++) begin
        for (int c = 0; c < LFX_COLS; c++) begin
          logic [7:0] base;
          logic [3:0] nib;
          base = disp_mem[disp_idx(page_q, 4'(r), 3'(c))];
          nib = 4'(fade_mem[fade_idx(page_q, 4'(r), 2'(c / 2))] >> (FX_NIB_W * (c % 2)));
          if (binary_mode) begin
            dot_level[r * LFX_COLS + c] <= disp_mem[disp_idx(page_q, 4'(r), 3'h0)][c] ? 8'hff : 8'h00;
          end else if (!mask_mem[r][c]) begin
            dot_level[r * LFX_COLS + c] <= 8'h00;
          end else if (nib[FX_MODE_BIT] == FX_MODE_FADE) begin
            dot_level[r * LFX_COLS + c] <= (base < fx_lvl[nib[2:0]]) ? base : fx_lvl[nib[2:0]];
          end else begin
            dot_level[r * LFX_COLS + c] <= fx_on[nib[2:0]] ? base : 8'h00;
          end
        end
      end
    end
  end

  assign page = page_q;
  assign frame_count = frame_q;

endmodule
`default_nettype wire

/* rtl/lfx_host.sv */
// Purpose: Host end; turns register writes into link frames and read strobes
// Assumes: Software waits 3 cycles after a HR_CMD write before the next access
// Notes: The dummy byte after a read command is dropped here, not by software
`default_nettype none
module lfx_host
  import lfx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  lfx_link_if.host link,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);

  lfx_host_state_e state_q;
  logic frm_q;
  logic wr_stb_q;
  logic [7:0] wr_data_q;
  logic rd_stb_q;
  logic [7:0] cmd_q;
  logic [7:0] arg_q;
  logic drop_q;
  logic dummy_pend_q;
  logic [1:0] rd_pend_q;
  logic rx_vld_q;
  logic [7:0] rx_q;
  logic [15:0] rdata_q;
  logic is_read_cmd;

  assign is_read_cmd = cmd_q == CMD_DISP_RD || cmd_q == CMD_FADE_RD || cmd_q == CMD_MASK_RD;

  ////////////////////////////////////////////////////////////////////////////
  // Frame and byte sequencing: close, command byte, address or page byte
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= HS_IDLE;
      frm_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_data_q <= 8'h00;
      cmd_q <= 8'h00;
      arg_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      case (state_q)
        HS_IDLE: begin
          if (reg_wr && reg_addr == HR_CMD) begin
            cmd_q <= reg_wdata[7:0];
            arg_q <= reg_wdata[15:8];
            frm_q <= 1'b0;
            state_q <= HS_CLOSE;
          end else if (reg_wr && reg_addr == HR_TX) begin
            wr_stb_q <= 1'b1;
            wr_data_q <= reg_wdata[7:0];
          end else if (reg_wr && reg_addr == HR_FRAME) begin
            frm_q <= reg_wdata[0];
          end
        end
        HS_CLOSE: state_q <= HS_CMD;
        HS_CMD: begin
          frm_q <= 1'b1;
          wr_stb_q <= 1'b1;
          wr_data_q <= cmd_q;
          state_q <= HS_ARG;
        end
        HS_ARG: begin
          wr_stb_q <= 1'b1;
          // Page byte goes out whole; the device keeps only the low nibble
          wr_data_q <= arg_q;
          state_q <= HS_IDLE;
        end
        default: state_q <= HS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read strobes; the first read after a read command fetches the dummy too
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dummy_pend_q <= 1'b0;
      rd_pend_q <= 2'd0;
      rd_stb_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      rd_stb_q <= rd_pend_q != 2'd0;
      if (state_q == HS_ARG) begin
        dummy_pend_q <= is_read_cmd;
      end
      if (reg_wr && reg_addr == HR_RX && state_q == HS_IDLE && rd_pend_q == 2'd0) begin
        rd_pend_q <= dummy_pend_q ? 2'd2 : 2'd1;
        drop_q <= dummy_pend_q;
        dummy_pend_q <= 1'b0;
      end else if (rd_pend_q != 2'd0) begin
        rd_pend_q <= 2'(rd_pend_q - 2'd1);
      end
      if (link.rd_vld && drop_q) begin
        drop_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Received byte; a new byte wins over the clear by reading HR_RX
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_vld_q <= 1'b0;
      rx_q <= 8'h00;
    end else if (link.rd_vld && !drop_q) begin
      rx_vld_q <= 1'b1;
      rx_q <= link.rd_data;
    end else if (reg_rd && reg_addr == HR_RX) begin
      rx_vld_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        HR_RX: rdata_q <= {7'h00, rx_vld_q, rx_q};
        HR_FRAME: rdata_q <= {15'h0000, frm_q};
        HR_STAT: rdata_q <= {12'h000, dummy_pend_q, rd_pend_q != 2'd0, state_q != HS_IDLE, rx_vld_q};
        HR_CMD: rdata_q <= {arg_q, cmd_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata = rdata_q;
  assign link.frm = frm_q;
  assign link.wr_stb = wr_stb_q;
  assign link.wr_data = wr_data_q;
  assign link.rd_stb = rd_stb_q;

endmodule
`default_nettype wire

/* test/lfx_link_asserts.sv */
// Purpose: Protocol checks on the byte link between host and device ends
// Assumes: One clock domain, rstn asynchronous active low
// Notes: Frame byte count is tracked here to tell read frames apart
`default_nettype none
module lfx_link_asserts
  import lfx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic frm,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  input wire logic rd_vld,
  input wire logic [7:0] rd_data
);
  logic [1:0] nb_q;
  logic [7:0] cmd_q;
  logic dummy_q;
  logic is_rd;

  // Page command is odd too, so compare codes instead of bit 0
  assign is_rd = (cmd_q == CMD_DISP_RD) || (cmd_q == CMD_FADE_RD) || (cmd_q == CMD_MASK_RD);

  ////////////////////////////////////////
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nb_q <= 2'h0;
    end else if (!frm) begin
      nb_q <= 2'h0;
    end else if (wr_stb && nb_q != 2'h3) begin
      nb_q <= nb_q + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= 8'h00;
    end else if (frm && wr_stb && nb_q == 2'h0) begin
      cmd_q <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dummy_q <= 1'b0;
    end else if (!frm) begin
      dummy_q <= 1'b0;
    end else if (wr_stb && nb_q == 2'h1 && is_rd) begin
      dummy_q <= 1'b1;
    end else if (rd_vld) begin
      dummy_q <= 1'b0;
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_req;
    frm && rd_stb;
  endsequence

  sequence s_frame_open;
    $rose(frm);
  endsequence

  AST_RD_ANSWER: assert property (s_rd_req |=> rd_vld) else $error("read not answered");
  AST_VLD_CAUSE: assert property (rd_vld |-> $past(rd_stb)) else $error("answer without request");
  AST_RD_IDLE: assert property (!rd_vld |-> rd_data == 8'h00) else $error("read data not idle");
  AST_DUMMY_FIRST: assert property (rd_vld && dummy_q |-> rd_data == DUMMY_BYTE) else $error("no dummy");
  AST_WR_IN_FRAME: assert property (wr_stb |-> frm) else $error("byte outside frame");
  AST_OPEN_CMD: assert property (s_frame_open |-> wr_stb && (wr_data == CMD_PAGE || wr_data[7:3] == 5'h10))
    else $error("frame opens without command");
  AST_RD_FRAME: assert property (rd_stb |-> frm && is_rd && nb_q == 2'h2) else $error("stray read");
  AST_NO_WR_IN_RD: assert property (frm && is_rd && nb_q == 2'h2 |-> !wr_stb) else $error("write in read");
endmodule
`default_nettype wire

/* test/test_led_dot_fade_mask_ram_access.sv */
// Purpose: Host and device ends joined; register-level traffic checked end to end
// Assumes: FRAME_CYCLES of 4 so one effect unit is 1024 cycles
// Notes: Dummy byte is dropped by the host, so checker watches it on the link
`default_nettype none
module test_led_dot_fade_mask_ram_access
  import lfx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk;
  logic rstn;
  logic binary_mode;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0] page;
  logic [15:0] frame_count;
  logic [LFX_DOTS-1:0][7:0] dot_level;
  int n_mismatch;
  int cmp_count;
  logic [7:0] b;
  logic [15:0] f0;
  logic [15:0] rv;

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  lfx_link_if i_lfx_link_if (.core_clk(core_clk), .rstn(rstn));
  lfx_dev #(.FRAME_CYCLES(4)) i_lfx_dev (.core_clk(core_clk), .rstn(rstn), .link(i_lfx_link_if),
    .binary_mode(binary_mode), .page(page), .frame_count(frame_count), .dot_level(dot_level));
  lfx_host i_lfx_host (.core_clk(core_clk), .rstn(rstn), .link(i_lfx_link_if), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  lfx_link_asserts u_link_chk (.core_clk(core_clk), .rstn(rstn), .frm(i_lfx_link_if.frm),
    .wr_stb(i_lfx_link_if.wr_stb), .wr_data(i_lfx_link_if.wr_data), .rd_stb(i_lfx_link_if.rd_stb),
    .rd_vld(i_lfx_link_if.rd_vld), .rd_data(i_lfx_link_if.rd_data));

  ////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Launch settles in 3 cycles; earlier writes would be dropped
  task automatic send_cmd(input logic [7:0] c, input logic [7:0] arg);
    reg_write(HR_CMD, {arg, c});
    repeat (3) @(posedge core_clk);
  endtask

  task automatic read_byte(output logic [7:0] v);
    logic [15:0] s;
    int i;
    reg_write(HR_RX, 16'h0000);
    s = 16'h0000;
    for (i = 0; i < 20 && s[0] !== 1'b1; i++) reg_read(HR_STAT, s);
    if (s[0] !== 1'b1) begin
      n_mismatch++;
      wrap_up();
    end
    reg_read(HR_RX, s);
    chk("rx valid", 16'h0001, {15'h0000, s[8]});
    v = s[7:0];
  endtask

  // Three bytes from a, read back three from ra
  task automatic seq(input logic [7:0] wc, input logic [7:0] a, input logic [23:0] d, input logic [7:0] ra);
    int i;
    logic [7:0] v;
    send_cmd(wc, a);
    for (i = 0; i < 3; i++) reg_write(HR_TX, {8'h00, d[8*i +: 8]});
    send_cmd(wc + 8'h01, ra);
    for (i = 0; i < 3; i++) begin
      read_byte(v);
      chk("read back", {8'h00, d[8*i +: 8]}, {8'h00, v});
    end
  endtask

  task automatic wait_ph(input logic [8:0] ph);
    int i;
    for (i = 0; i < 3000 && frame_count[8:0] !== ph; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 3000) begin
      n_mismatch++;
      wrap_up();
    end
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  ////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    binary_mode = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk("page", 16'h0000, {12'h000, page});
    chk("frame", 16'h0000, frame_count);
    send_cmd(CMD_MASK_RD, 8'h00);
    read_byte(b);
    chk("mask", 16'h00ff, {8'h00, b});
    $display("test reset done");
    seq(CMD_FADE_WR, 8'h82, 24'h7e3ca5, 8'h82);
    seq(CMD_DISP_WR, 8'h86, 24'h5a1122, 8'h86);
    seq(CMD_MASK_WR, 8'h28, 24'hffbfff, 8'h08);
    $display("test wrap done");
    send_cmd(CMD_PAGE, 8'hf3);
    repeat (3) @(posedge core_clk);
    #1;
    chk("page", 16'h0003, {12'h000, page});
    reg_read(HR_CMD, rv);
    chk("last cmd", 16'hf3fd, rv);
    seq(CMD_FADE_WR, 8'h00, 24'h332211, 8'h00);
    send_cmd(CMD_PAGE, 8'h00);
    send_cmd(CMD_FADE_RD, 8'h00);
    read_byte(b);
    chk("page 0 fade", 16'h007e, {8'h00, b});
    $display("test page done");
    seq(CMD_FADE_WR, 8'h00, 24'h000190, 8'h00);
    send_cmd(CMD_DISP_WR, 8'h01);
    for (int i = 0; i < 6; i++) reg_write(HR_TX, 16'h00ff);
    @(posedge core_clk);
    #1;
    f0 = frame_count;
    repeat (32) @(posedge core_clk);
    #1;
    chk("frame step", f0 + 16'd8, frame_count);
    wait_ph(9'h080);
    chk("blink on", 16'h00ff, {8'h00, dot_level[1]});
    chk("off dot", 16'h005a, {8'h00, dot_level[0]});
    chk("masked", 16'h0000, {8'h00, dot_level[6]});
    chk("fade up", 16'h0080, {8'h00, dot_level[2] & 8'hf0});
    wait_ph(9'h180);
    chk("blink off", 16'h0000, {8'h00, dot_level[1]});
    chk("fade down", 16'h0070, {8'h00, dot_level[2] & 8'hf0});
    @(posedge core_clk);
    binary_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("bin blink", 16'h0001, {15'h0000, |dot_level[1]});
    chk("bin mask", 16'h0001, {15'h0000, |dot_level[6]});
    chk("bin bit", 16'h0000, {15'h0000, |dot_level[0]});
    seq(CMD_DISP_WR, 8'h08, 24'h0f817e, 8'h08);
    chk("bin write", 16'h0001, {15'h0000, |dot_level[0]});
    $display("test effect done");
    wrap_up();
  end
endmodule
`default_nettype wire
